//--- core/io_cell.sv
// Configurable pad cell: input path with direct and registered copies of
// the pad, output path with optional inversion and register, and a
// tristate enable of selectable polarity.
// Assumes pad, register clocks and the global set/reset net come from
// outside the clk domain; logic data and tristate control are on clk.
`timescale 1ns/100ps
`default_nettype none

module io_cell
  import io_cell_pkg::*;
(
  input  wire logic clk,              // System clock, 250 MHz
  input  wire logic srst,             // Synchronous reset, active high
  input  wire logic ce,               // Clock enable, freezes all state when low
  input  wire logic pad_in,           // Level seen at the pad
  output logic      pad_out,          // Value driven onto the pad
  output logic      pad_oe,           // High while the cell drives the pad
  output logic      input_path_a,     // First input path to internal logic
  output logic      input_path_b,     // Second input path to internal logic
  input  wire logic out_data,         // Value from internal logic for the pad
  input  wire logic tristate_ctrl,    // Tristate control from internal logic
  input  wire logic in_reg_clk,       // Clock of the input flop
  input  wire logic out_reg_clk,      // Clock of the output flop
  input  wire logic global_sr,        // Global set/reset net, active high
  input  wire logic cfg_a_sel,        // Path A source: direct or registered
  input  wire logic cfg_b_sel,        // Path B source: direct or registered
  input  wire logic cfg_out_invert,   // Drive the complement of out_data
  input  wire logic cfg_out_sel,      // Pad from logic or from output flop
  input  wire logic cfg_ts_invert,    // Tristate control is active low
  input  wire logic cfg_in_clk_inv,   // Input flop captures on falling edge
  input  wire logic cfg_out_clk_inv,  // Output flop captures on falling edge
  input  wire logic cfg_in_init,      // Initial value of the input flop
  input  wire logic cfg_out_init      // Initial value of the output flop
);
  import io_cell_pkg::*;

  // Pad synchroniser
  logic pad_s1_r;        // First stage, read only by the second
  logic pad_s2_r;        // Synchronised pad level
  logic pad_s1_nxt;
  logic pad_s2_nxt;

  // Global set/reset synchroniser
  logic gsr_s1_r;        // First stage, read only by the second
  logic gsr_s2_r;        // Synchronised set/reset level
  logic gsr_s1_nxt;
  logic gsr_s2_nxt;

  // Cell storage
  logic in_reg_r;        // Input flop
  logic out_reg_r;       // Output flop
  logic in_reg_nxt;
  logic out_reg_nxt;

  // Registered outputs
  logic path_a_r;
  logic path_b_r;
  logic pad_out_r;
  logic pad_oe_r;
  logic path_a_nxt;
  logic path_b_nxt;
  logic pad_out_nxt;
  logic pad_oe_nxt;

  // Derived values
  logic in_edge;         // Capture strobe for the input flop
  logic out_edge;        // Capture strobe for the output flop
  logic out_value;       // Logic value after optional inversion
  logic ts_active;       // Tristate control after polarity choice

  // Picks the direct or registered copy for an input path
  function automatic logic path_pick(input logic sel, input logic direct,
                                     input logic stored);
    path_pick = (sel == SEL_REGISTERED) ? stored : direct;
  endfunction

  // Separate clock strobe for the input flop
  clock_edge_select u_in_edge (
    .clk        (clk),
    .srst       (srst),
    .ce         (ce),
    .clk_in     (in_reg_clk),
    .invert     (cfg_in_clk_inv),
    .edge_pulse (in_edge)
  );

  // Separate clock strobe for the output flop
  clock_edge_select u_out_edge (
    .clk        (clk),
    .srst       (srst),
    .ce         (ce),
    .clk_in     (out_reg_clk),
    .invert     (cfg_out_clk_inv),
    .edge_pulse (out_edge)
  );

  // Optional inversion of the outgoing value
  assign out_value = out_data ^ cfg_out_invert;
  // Tristate control polarity
  assign ts_active = tristate_ctrl ^ cfg_ts_invert;

  // Next-state for the synchronisers
  always_comb begin
    pad_s1_nxt = pad_s1_r;
    pad_s2_nxt = pad_s2_r;
    gsr_s1_nxt = gsr_s1_r;
    gsr_s2_nxt = gsr_s2_r;
    if (srst) begin
      pad_s1_nxt = SYNC_RST;
      pad_s2_nxt = SYNC_RST;
      gsr_s1_nxt = SYNC_RST;
      gsr_s2_nxt = SYNC_RST;
    end else if (ce) begin
      pad_s1_nxt = pad_in;
      pad_s2_nxt = pad_s1_r;
      gsr_s1_nxt = global_sr;
      gsr_s2_nxt = gsr_s1_r;
    end
  end

  // Synchroniser registers
  always_ff @(posedge clk) begin
    pad_s1_r <= pad_s1_nxt;
    pad_s2_r <= pad_s2_nxt;
    gsr_s1_r <= gsr_s1_nxt;
    gsr_s2_r <= gsr_s2_nxt;
  end

  // Next-state for the two cell flops
  always_comb begin
    in_reg_nxt  = in_reg_r;
    out_reg_nxt = out_reg_r;
    if (srst) begin
      // Reset loads the configured initial state
      in_reg_nxt  = cfg_in_init;
      out_reg_nxt = cfg_out_init;
    end else if (ce) begin
      if (gsr_s2_r) begin
        // Set/reset wins over any capture strobe
        in_reg_nxt  = cfg_in_init;
        out_reg_nxt = cfg_out_init;
      end else begin
        // Each flop captures on its own strobe only
        if (in_edge) begin
          in_reg_nxt = pad_s2_r;
        end
        if (out_edge) begin
          out_reg_nxt = out_value;
        end
      end
    end
  end

  // Cell flop registers
  always_ff @(posedge clk) begin
    in_reg_r  <= in_reg_nxt;
    out_reg_r <= out_reg_nxt;
  end

  // Next-state for the registered outputs
  always_comb begin
    path_a_nxt  = path_a_r;
    path_b_nxt  = path_b_r;
    pad_out_nxt = pad_out_r;
    pad_oe_nxt  = pad_oe_r;
    if (srst) begin
      path_a_nxt  = PATH_RST;
      path_b_nxt  = PATH_RST;
      pad_out_nxt = PAD_OUT_RST;
      pad_oe_nxt  = PAD_OE_RST;
    end else if (ce) begin
      // Each input path selects independently
      path_a_nxt  = path_pick(cfg_a_sel, pad_s2_r, in_reg_r);
      path_b_nxt  = path_pick(cfg_b_sel, pad_s2_r, in_reg_r);
      // Pad driven from logic or from the output flop
      pad_out_nxt = (cfg_out_sel == OUT_FLOP) ? out_reg_r : out_value;
      // Active tristate control releases the driver
      pad_oe_nxt  = ~ts_active;
    end
  end

  // Output registers
  always_ff @(posedge clk) begin
    path_a_r  <= path_a_nxt;
    path_b_r  <= path_b_nxt;
    pad_out_r <= pad_out_nxt;
    pad_oe_r  <= pad_oe_nxt;
  end

  // Data outputs come from flops
  assign input_path_a = path_a_r;
  assign input_path_b = path_b_r;
  assign pad_out      = pad_out_r;
  assign pad_oe       = pad_oe_r;

  // Set/reset forces the input flop to its initial value
  a_gsr_in_init: assert property (@(posedge clk) disable iff (srst)
    (gsr_s2_r && ce) |=> (in_reg_r == $past(cfg_in_init)))
    else $error("input flop not forced by set/reset");

  // Set/reset forces the output flop to its initial value
  a_gsr_out_init: assert property (@(posedge clk) disable iff (srst)
    (gsr_s2_r && ce) |=> (out_reg_r == $past(cfg_out_init)))
    else $error("output flop not forced by set/reset");

  // Input flop takes the pad level on its strobe
  a_in_capture: assert property (@(posedge clk) disable iff (srst)
    (in_edge && !gsr_s2_r && ce) |=> (in_reg_r == $past(pad_s2_r)))
    else $error("input flop missed its capture");

  // Input flop holds between strobes
  a_in_hold: assert property (@(posedge clk) disable iff (srst)
    (!in_edge && !gsr_s2_r && ce) |=> $stable(in_reg_r))
    else $error("input flop changed without a strobe");

  // Output flop takes the possibly inverted value on its strobe
  a_out_capture: assert property (@(posedge clk) disable iff (srst)
    (out_edge && !gsr_s2_r && ce) |=> (out_reg_r == $past(out_data ^ cfg_out_invert)))
    else $error("output flop captured a wrong value");

  // Path A shows the selected source one cycle later
  a_path_a_sel: assert property (@(posedge clk) disable iff (srst)
    ce |=> (input_path_a == ($past(cfg_a_sel) ? $past(in_reg_r) : $past(pad_s2_r))))
    else $error("path A shows the wrong source");

  // Path B shows the selected source one cycle later
  a_path_b_sel: assert property (@(posedge clk) disable iff (srst)
    ce |=> (input_path_b == ($past(cfg_b_sel) ? $past(in_reg_r) : $past(pad_s2_r))))
    else $error("path B shows the wrong source");

  // Pad value follows the selected output route
  a_pad_route: assert property (@(posedge clk) disable iff (srst)
    ce |=> (pad_out == ($past(cfg_out_sel) ? $past(out_reg_r) : $past(out_value))))
    else $error("pad value from the wrong route");

  // Driver released exactly while the corrected control is active
  a_tristate_pol: assert property (@(posedge clk) disable iff (srst)
    ce |=> (pad_oe == !$past(tristate_ctrl ^ cfg_ts_invert)))
    else $error("pad enable disagrees with tristate control");

endmodule

`default_nettype wire

//--- core/io_cell_pkg.sv
// Constants shared by the configurable pad cell and its clock-edge selector.
// Assumes one system clock; all strobes and pad levels are sampled on it.
package io_cell_pkg;

  // Width of every single-bit path through the cell
  localparam int unsigned BIT_W          = 1;

  // Values held by the output and synchroniser flops while the system reset is high
  localparam logic        PAD_OUT_RST    = 1'h0;  // Pad drive value during reset
  localparam logic        PAD_OE_RST     = 1'h0;  // Driver released during reset
  localparam logic        PATH_RST       = 1'h0;  // Input-path outputs during reset
  localparam logic        SYNC_RST       = 1'h0;  // Synchroniser stages during reset

  // Configuration encodings for the two input-path selectors
  localparam logic        SEL_DIRECT     = 1'h0;  // Present the synchronised pad level, bypassing the input flop
  localparam logic        SEL_REGISTERED = 1'h1;  // Present the input flop

  // Configuration encodings for the output-path selector
  localparam logic        OUT_COMB       = 1'h0;  // Pad follows the logic value
  localparam logic        OUT_FLOP       = 1'h1;  // Pad follows the output flop

endpackage

//--- core/clock_edge_select.sv
// Clock-edge selector: brings a slow register clock into the system clock
// domain and emits a one-cycle capture strobe on the chosen edge.
// Assumes the incoming clock is far slower than clk and is unrelated to it.
`timescale 1ns/100ps
`default_nettype none

module clock_edge_select
  import io_cell_pkg::*;
(
  input  wire logic clk,        // System clock
  input  wire logic srst,       // Synchronous reset, active high
  input  wire logic ce,         // Clock enable, freezes all state when low
  input  wire logic clk_in,     // Register clock from outside this domain
  input  wire logic invert,     // High selects the falling edge
  output logic      edge_pulse  // One-cycle strobe on the selected edge
);
  import io_cell_pkg::*;

  logic s1_r;       // First synchroniser stage
  logic s2_r;       // Second synchroniser stage
  logic prev_r;     // Previous polarity-corrected level
  logic s1_nxt;     // Next first stage
  logic s2_nxt;     // Next second stage
  logic prev_nxt;   // Next history bit
  logic level;      // Synchronised clock after polarity choice

  // Polarity is assumed static; flipping it in operation can fake an edge
  assign level      = s2_r ^ invert;
  // Strobe on a rising edge of the corrected level
  assign edge_pulse = level & ~prev_r;

  // Next-state for the synchroniser and edge history
  always_comb begin
    s1_nxt   = s1_r;
    s2_nxt   = s2_r;
    prev_nxt = prev_r;
    if (srst) begin
      s1_nxt   = SYNC_RST;
      s2_nxt   = SYNC_RST;
      prev_nxt = SYNC_RST ^ invert;
    end else if (ce) begin
      s1_nxt   = clk_in;
      s2_nxt   = s1_r;
      prev_nxt = level;
    end
  end

  // Registers only
  always_ff @(posedge clk) begin
    s1_r   <= s1_nxt;
    s2_r   <= s2_nxt;
    prev_r <= prev_nxt;
  end

  // A strobe never lasts two enabled cycles
  a_edge_single: assert property (@(posedge clk) disable iff (srst)
    (edge_pulse && ce) |=> !edge_pulse)
    else $error("capture strobe held longer than one cycle");

endmodule

`default_nettype wire

//--- tb/pad_model.sv
// Model of the external pad: resolves the wire from the cell driver and
// an outside driver. A released, undriven pad toggles every cycle.
// Assumes both drivers are sampled on the system clock domain.
`timescale 1ns/100ps
`default_nettype none

module pad_model (
  input  wire logic clk,      // System clock
  input  wire logic pad_out,  // Cell drive value
  input  wire logic pad_oe,   // Cell drives the pad
  input  wire logic ext_en,   // Outside driver active
  input  wire logic ext_val,  // Outside drive value
  output logic      pad_in    // Resolved pad level
);
  logic float_r = 1'h0;       // Floating-pad pattern

  // Undriven pad never holds its last value
  always @(posedge clk) begin
    float_r <= ~float_r;
  end

  // Contention shows as unknown
  assign pad_in = pad_oe ? (ext_en ? 1'bx : pad_out) : (ext_en ? ext_val : float_r);
endmodule

`default_nettype wire

//--- tb/test_io_cell.sv
// Self-checking bench for the configurable pad cell.
// Assumes io_cell_pkg, io_cell and pad_model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module test_io_cell;
  import io_cell_pkg::*;

  typedef struct {int at; int sel; logic exp;} note_t;

  logic  clk = 1'h0, srst = 1'h1, ce = 1'h1;           // Clock, reset, enable
  logic  pad_in, pad_out, pad_oe, path_a, path_b;      // Observed signals
  logic  out_data = 1'h0, ts = 1'h0, gsr = 1'h0;       // Logic-side stimulus
  logic  in_clk = 1'h0, out_clk = 1'h0;                // Register clocks
  logic  a_sel = 1'h0, b_sel = 1'h0, oinv = 1'h0, tsinv = 1'h0, out_sel = 1'h0;
  logic  iinv = 1'h0, ocinv = 1'h0, iinit = 1'h0, oinit = 1'h0;
  logic  ext_en = 1'h0, ext_val = 1'h0;                // Outside pad driver
  int    cyc = 0, bad_count = 0, n_tests = 0;          // Counters
  note_t q[$];                                         // Expected results
  logic  pv, ov;                                       // Last accepted pad value and enable

  io_cell uut (.clk(clk), .srst(srst), .ce(ce), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .input_path_a(path_a), .input_path_b(path_b),
    .out_data(out_data), .tristate_ctrl(ts), .in_reg_clk(in_clk),
    .out_reg_clk(out_clk), .global_sr(gsr), .cfg_a_sel(a_sel), .cfg_b_sel(b_sel),
    .cfg_out_invert(oinv), .cfg_out_sel(out_sel), .cfg_ts_invert(tsinv),
    .cfg_in_clk_inv(iinv), .cfg_out_clk_inv(ocinv), .cfg_in_init(iinit),
    .cfg_out_init(oinit));

  pad_model pad (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));

  // 250 MHz clock
  always #2 clk = ~clk;

  // Cycle count and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end

  task check(input logic seen, input logic exp, input string msg);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t %s: saw %b expected %b", $time, msg, seen, exp);
    end
  endtask

  task end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Inputs change one small delay after the rising edge
  task step();
    @(posedge clk);
    #1;
  endtask

  task note(input int d, input int s, input logic e);
    q.push_back('{cyc + d, s, e});
  endtask

  task restart();
    srst = 1'h1;
    repeat (4) step();
    srst = 1'h0;
  endtask

  // Registered paths A and B and pad value; the idle side keeps its init
  task both(input logic w, input logic e, input logic init);
    note(0, 3, w ? init : e);
    note(0, 2, w ? init : e);
    note(0, 0, w ? e : init);
  endtask

  // Selected and unselected clock edges, then global set/reset
  task automatic edge_test(input logic w, input logic inv);
    logic init;
    logic x;
    init = inv ^ w;
    x = w & 1'($urandom);
    a_sel = SEL_REGISTERED;
    b_sel = SEL_REGISTERED;
    out_sel = OUT_FLOP;
    oinv = x;
    iinv = inv;
    ocinv = inv;
    iinit = init;
    oinit = init;
    ext_val = init;
    out_data = init ^ x;
    restart();
    repeat (8) step();
    both(w, init, init);
    ext_val = ~init;
    out_data = ~init;
    repeat (4) step();
    if (w) out_clk = 1'h1;
    else in_clk = 1'h1;
    repeat (8) step();
    both(w, inv ? init : ~init ^ x, init);
    ext_val = inv ? ~init : init;
    out_data = ext_val;
    repeat (4) step();
    if (w) out_clk = 1'h0;
    else in_clk = 1'h0;
    repeat (8) step();
    both(w, ~init ^ x, init);
    gsr = 1'h1;
    repeat (8) step();
    both(w, init, init);
    gsr = 1'h0;
    repeat (6) step();
  endtask

  // Compares every due note, oldest first, once its cycle has come
  always @(negedge clk) begin
    while (q.size() > 0 && q[0].at <= cyc) begin
      case (q[0].sel)
        0: check(pad_out, q[0].exp, "pad value");
        1: check(pad_oe, q[0].exp, "pad enable");
        2: check(path_a, q[0].exp, "path a");
        default: check(path_b, q[0].exp, "path b");
      endcase
      void'(q.pop_front());
    end
  end

  initial begin
    void'($urandom(32'haf74395a));
    // Combinational output route, every inversion setting
    for (int k = 0; k < 4; k++) begin
      {tsinv, oinv} = k[1:0];
      out_sel = OUT_COMB;
      restart();
      pv = PAD_OUT_RST;
      ov = PAD_OE_RST;
      repeat (12) begin
        out_data = 1'($urandom);
        ts = 1'($urandom);
        ce = 1'($urandom);
        // A disabled edge leaves both outputs frozen
        if (ce) begin
          pv = out_data ^ oinv;
          ov = ~(ts ^ tsinv);
        end
        note(1, 0, pv);
        note(1, 1, ov);
        step();
      end
      ce = 1'h1;
    end
    $display("test output route done");
    // Direct input paths with the driver released
    a_sel = SEL_DIRECT;
    b_sel = SEL_DIRECT;
    ts = 1'h1;
    tsinv = 1'h0;
    ext_en = 1'h1;
    restart();
    step();
    repeat (16) begin
      ext_val = 1'($urandom);
      note(3, 2, ext_val);
      note(3, 3, ext_val);
      step();
    end
    repeat (4) step();
    $display("test direct input done");
    // Register clocks, edges and set/reset
    for (int k = 0; k < 4; k++) begin
      edge_test(k[1], k[0]);
    end
    $display("test registers done");
    end_sim();
  end
endmodule

`default_nettype wire
